// ===== shared/etctc_pkg.sv
// Constants and register layout of the edge timing control block
package etctc_pkg;
    localparam logic [15:0] ETCTC_CTRL_OFF = 16'ha200;
    localparam logic [1:0] ETCTC_ALIAS_WR = 2'h0;
    localparam logic [1:0] ETCTC_ALIAS_CLR = 2'h1;
    localparam logic [1:0] ETCTC_ALIAS_SET = 2'h2;
    localparam logic [1:0] ETCTC_ALIAS_INV = 2'h3;
    localparam logic [31:0] ETCTC_CTRL_RESET = 32'h0000_0000;
    // Bits 17:16 and 14 are unimplemented and read as zero
    localparam logic [31:0] ETCTC_WMASK = 32'hfffc_bfff;
    localparam int ETCTC_E2_STAT_BIT = 25;
    localparam int ETCTC_E1_STAT_BIT = 24;
    localparam logic [31:0] ETCTC_SW_MASK = ETCTC_WMASK
        & ~(32'h1 << ETCTC_E2_STAT_BIT) & ~(32'h1 << ETCTC_E1_STAT_BIT);
    localparam int ETCTC_MODE_BIT [2] = '{31, 23};
    localparam int ETCTC_POL_BIT [2] = '{30, 22};
    localparam int ETCTC_SEL_LSB [2] = '{26, 18};
    localparam int ETCTC_ON_BIT = 15;
    localparam int ETCTC_SIDL_BIT = 13;
    localparam int ETCTC_PULSE_DELAY_GEN_ENABLE_BIT = 12;
    localparam int ETCTC_EDGEN_BIT = 11;
    localparam int ETCTC_SEQEN_BIT = 10;
    localparam int ETCTC_DISCH_BIT = 9;
    localparam int ETCTC_TRIG_BIT = 8;
    localparam int ETCTC_TRIM_LSB = 2;
    localparam int ETCTC_RNG_LSB = 0;
    localparam logic [3:0] ETCTC_SRC_TIMER = 4'h0;
    localparam logic [3:0] ETCTC_SRC_COMPARE = 4'h1;
    localparam logic [3:0] ETCTC_SRC_PIN2 = 4'h2;
    localparam logic [3:0] ETCTC_SRC_PIN1 = 4'h3;
    localparam logic [3:0] ETCTC_SRC_PIN3 = 4'h4;
    localparam logic [3:0] ETCTC_SRC_CAP1 = 4'ha;
    localparam logic [3:0] ETCTC_SRC_CMP1 = 4'hd;
    localparam logic [3:0] ETCTC_SRC_CMP2 = 4'he;
    localparam logic [3:0] ETCTC_SRC_RSVD = 4'hf;

    typedef enum logic [1:0] {
        ETCTC_PH_IDLE = 2'b00,
        ETCTC_PH_WRITE = 2'b01,
        ETCTC_PH_RWAIT = 2'b10,
        ETCTC_PH_RDONE = 2'b11
    } etctc_phase_t;
endpackage

// ===== rtl/etctc_edge_chan.sv
// One edge channel: source select and edge or level qualification
`timescale 1ns/1ps
module etctc_edge_chan
    import etctc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [15:0] src_vec,
    input wire logic [3:0] source_sel,
    input wire logic sense_mode,
    input wire logic polarity,
    output logic hit
);
    typedef struct packed {
        logic [15:0] prev;
    } etctc_chan_t;

    etctc_chan_t s;
    etctc_chan_t next_s;
    logic level;

    // Reserved code is tied low in src_vec, so it hits only in level mode at low polarity
    assign level = src_vec[source_sel];

    always_comb
    begin
        next_s = s;
        // All sources are tracked, so a source change is no edge
        next_s.prev = src_vec;
        if (sense_mode)
        begin
            // Edge only when the sample moves into the active level
            hit = (level == polarity)
                && (s.prev[source_sel] != polarity);
        end
        else
        begin
            hit = (level == polarity);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    rise_edge_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        sense_mode && polarity && $stable(source_sel) && $rose(level)
        |-> hit)
    else $error("rising edge not reported");

    fall_edge_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        sense_mode && !polarity && $stable(source_sel) && $fell(level)
        |-> hit)
    else $error("falling edge not reported");

    level_hold_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (!sense_mode && (level == polarity)) [*2] |-> hit)
    else $error("level mode must report every active cycle");

    edge_once_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        sense_mode && hit |=> !hit || !sense_mode || $changed(polarity)
        || $changed(source_sel))
    else $error("edge mode reported twice for one edge");
endmodule

// ===== rtl/etctc_top.sv
// Edge timing control block with its AHB-Lite control register
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
module etctc_top
    import etctc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic timer_event,
    input wire logic compare_event,
    input wire logic [2:0] capture_event,
    input wire logic comparator1_output,
    input wire logic comparator2_output,
    input wire logic [7:0] edge_pin,
    output logic unit_enable,
    output logic stop_in_idle,
    output logic edge1_occurred,
    output logic edge2_occurred,
    output logic current_source_on,
    output logic pulse_delay_gen_enable,
    output logic sample_cap_discharge_enable,
    output logic adc_trigger,
    output logic [5:0] current_trim,
    output logic [1:0] current_range
);
    typedef struct packed {
        logic [31:0] ctrl;
        etctc_phase_t phase;
        logic mapped;
        logic [1:0] alias_sel;
        logic [31:0] rdata;
        logic trig;
    } etctc_state_t;

    etctc_state_t s;
    etctc_state_t next_s;
    logic [15:0] src_vec;
    logic [1:0] hit;
    logic take;
    logic armed;
    logic set1;
    logic set2;
    logic [31:0] sw_ctrl;

    // Source map; edge_pin[0] is pin 1, and pins 1 and 2 swap codes
    always_comb
    begin
        src_vec = 16'h0000;
        src_vec[ETCTC_SRC_TIMER] = timer_event;
        src_vec[ETCTC_SRC_COMPARE] = compare_event;
        src_vec[ETCTC_SRC_PIN2] = edge_pin[1];
        src_vec[ETCTC_SRC_PIN1] = edge_pin[0];
        src_vec[ETCTC_SRC_PIN3 +: 6] = edge_pin[7:2];
        src_vec[ETCTC_SRC_CAP1 +: 3] = capture_event;
        src_vec[ETCTC_SRC_CMP1] = comparator1_output;
        src_vec[ETCTC_SRC_CMP2] = comparator2_output;
        src_vec[ETCTC_SRC_RSVD] = 1'b0;
    end

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            etctc_edge_chan u_chan (
                .hclk(hclk),
                .hresetn(hresetn),
                .src_vec(src_vec),
                .source_sel(s.ctrl[ETCTC_SEL_LSB[ch] +: 4]),
                .sense_mode(s.ctrl[ETCTC_MODE_BIT[ch]]),
                .polarity(s.ctrl[ETCTC_POL_BIT[ch]]),
                .hit(hit[ch])
            );
        end
    endgenerate

    assign take = hsel && htrans[1] && hready;
    assign armed = s.ctrl[ETCTC_ON_BIT] && s.ctrl[ETCTC_EDGEN_BIT];
    assign set1 = armed && hit[0];
    // Sequencing holds edge two off until edge one has been seen
    assign set2 = armed && hit[1] && (!s.ctrl[ETCTC_SEQEN_BIT]
        || s.ctrl[ETCTC_E1_STAT_BIT]);

    always_comb
    begin
        next_s = s;
        next_s.trig = 1'b0;
        sw_ctrl = s.ctrl;
        if (s.phase == ETCTC_PH_WRITE && s.mapped)
        begin
            case (s.alias_sel)
                ETCTC_ALIAS_WR: sw_ctrl = hwdata;
                ETCTC_ALIAS_CLR: sw_ctrl = s.ctrl & ~hwdata;
                ETCTC_ALIAS_SET: sw_ctrl = s.ctrl | hwdata;
                ETCTC_ALIAS_INV: sw_ctrl = s.ctrl ^ hwdata;
                default: sw_ctrl = s.ctrl;
            endcase
        end
        sw_ctrl = sw_ctrl & ETCTC_WMASK;
        // Hardware set wins over a clear in the same cycle
        if (set1)
        begin
            sw_ctrl[ETCTC_E1_STAT_BIT] = 1'b1;
        end
        if (set2)
        begin
            sw_ctrl[ETCTC_E2_STAT_BIT] = 1'b1;
            next_s.trig = s.ctrl[ETCTC_TRIG_BIT]
                && !s.ctrl[ETCTC_E2_STAT_BIT];
        end
        next_s.ctrl = sw_ctrl;
        case (s.phase)
            ETCTC_PH_RWAIT:
            begin
                next_s.rdata = s.mapped ? s.ctrl : 32'h0000_0000;
                next_s.phase = ETCTC_PH_RDONE;
            end
            ETCTC_PH_WRITE, ETCTC_PH_RDONE:
            begin
                next_s.phase = ETCTC_PH_IDLE;
            end
            ETCTC_PH_IDLE:
            begin
                next_s.phase = ETCTC_PH_IDLE;
            end
            default:
            begin
                next_s.phase = ETCTC_PH_IDLE;
            end
        endcase
        // Only whole words; hsize is not checked, unmapped reads give zero
        if (take)
        begin
            next_s.mapped = (haddr[15:4] == ETCTC_CTRL_OFF[15:4]);
            next_s.alias_sel = haddr[3:2];
            next_s.phase = hwrite ? ETCTC_PH_WRITE : ETCTC_PH_RWAIT;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s <= '{ctrl: ETCTC_CTRL_RESET, phase: ETCTC_PH_IDLE,
                mapped: 1'b0, alias_sel: 2'h0, rdata: 32'h0000_0000,
                trig: 1'b0};
        end
        else
        begin
            s <= next_s;
        end
    end

    // Reads take one wait state so that read data leaves a flip-flop
    assign hreadyout = (s.phase != ETCTC_PH_RWAIT);
    assign hresp = 1'b0;
    assign hrdata = s.rdata;

    assign unit_enable = s.ctrl[ETCTC_ON_BIT];
    assign stop_in_idle = s.ctrl[ETCTC_SIDL_BIT];
    assign edge1_occurred = s.ctrl[ETCTC_E1_STAT_BIT];
    assign edge2_occurred = s.ctrl[ETCTC_E2_STAT_BIT];
    // Current flows between the two edges of a measurement
    assign current_source_on = armed && edge1_occurred && !edge2_occurred;
    // Comparator-two source for pulse delay is left to software
    assign pulse_delay_gen_enable = s.ctrl[ETCTC_PULSE_DELAY_GEN_ENABLE_BIT];
    // Sink is gated by the converter's sampling, not here
    assign sample_cap_discharge_enable = s.ctrl[ETCTC_DISCH_BIT];
    assign adc_trigger = s.trig;
    assign current_trim = s.ctrl[ETCTC_TRIM_LSB +: 6];
    assign current_range = s.ctrl[ETCTC_RNG_LSB +: 2];

    sequence rd_taken_s;
        hsel && htrans[1] && hready && !hwrite;
    endsequence

    sequence rd_answer_s;
        !hreadyout ##1 hreadyout;
    endsequence

    read_wait_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        rd_taken_s |=> rd_answer_s)
    else $error("read answer not one wait state");

    read_data_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_taken_s and (haddr[15:4] == ETCTC_CTRL_OFF[15:4]))
        |=> ##1 hrdata == $past(s.ctrl))
    else $error("read data does not match control register");

    set_alias_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        s.phase == ETCTC_PH_WRITE && s.mapped
        && s.alias_sel == ETCTC_ALIAS_SET
        |=> (s.ctrl & ETCTC_SW_MASK)
        == (($past(s.ctrl) | $past(hwdata)) & ETCTC_SW_MASK))
    else $error("set alias wrong");

    clr_alias_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        s.phase == ETCTC_PH_WRITE && s.mapped
        && s.alias_sel == ETCTC_ALIAS_CLR
        |=> (s.ctrl & ETCTC_SW_MASK)
        == (($past(s.ctrl) & ~$past(hwdata)) & ETCTC_SW_MASK))
    else $error("clear alias wrong");

    inv_alias_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        s.phase == ETCTC_PH_WRITE && s.mapped
        && s.alias_sel == ETCTC_ALIAS_INV
        |=> (s.ctrl & ETCTC_SW_MASK)
        == (($past(s.ctrl) ^ $past(hwdata)) & ETCTC_SW_MASK))
    else $error("invert alias wrong");

    edge1_set_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        armed && hit[0] |=> edge1_occurred)
    else $error("edge one status not set");

    edge2_set_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        armed && hit[1] && !s.ctrl[ETCTC_SEQEN_BIT] |=> edge2_occurred)
    else $error("edge two status not set");

    edge2_hold_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        !armed && !(s.phase == ETCTC_PH_WRITE && s.mapped)
        |=> $stable(edge2_occurred))
    else $error("edge two status changed with no cause");

    reserved_src_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        s.ctrl[ETCTC_SEL_LSB[0] +: 4] == ETCTC_SRC_RSVD
        && s.ctrl[ETCTC_MODE_BIT[0]] |-> !hit[0])
    else $error("reserved source produced an edge");

    unused_bits_a:
    assert property (@(posedge hclk) disable iff (!hresetn)
        (s.ctrl & ~ETCTC_WMASK) == 32'h0000_0000)
    else $error("unimplemented bits set");
endmodule

// ===== verif/etctc_src_model.sv
// Model of the event sources that feed the two edge channels
`timescale 1ns/1ps
module etctc_src_model
(
    input wire logic [3:0] code,
    input wire logic lvl,
    output logic timer_event,
    output logic compare_event,
    output logic [2:0] capture_event,
    output logic comparator1_output,
    output logic comparator2_output,
    output logic [7:0] edge_pin
);
    logic [15:0] v;
    // Unselected sources sit opposite, so a wrong decode shows
    always_comb
    begin
        v = {16{~lvl}};
        v[code] = lvl;
    end
    assign timer_event = v[0];
    assign compare_event = v[1];
    assign capture_event = v[12:10];
    assign comparator1_output = v[13];
    assign comparator2_output = v[14];
    // Pin two sits below pin one in the code order
    assign edge_pin = {v[9:4], v[2], v[3]};
endmodule

// ===== verif/tb_edge_triggered_charge_timing_control.sv
// Self-checking bench of the edge timing control block
`timescale 1ns/1ps
module tb_edge_triggered_charge_timing_control;
    import etctc_pkg::*;
    logic hclk = 0;
    logic hresetn = 0;
    logic hsel = 0;
    logic hwrite = 0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd, ev, d;
    logic [31:0] r = 32'hd929;
    logic hreadyout, hresp, timer_event, compare_event;
    logic comparator1_output, comparator2_output;
    logic [2:0] capture_event;
    logic [7:0] edge_pin;
    logic unit_enable, stop_in_idle, edge1_occurred, edge2_occurred;
    logic current_source_on, pulse_delay_gen_enable, adc_trigger;
    logic sample_cap_discharge_enable;
    logic [5:0] current_trim;
    logic [1:0] current_range;
    logic [3:0] code = 4'h0;
    logic lvl = 0;
    int failures = 0;
    int checks = 0;
    int cyc = 0;

    etctc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .timer_event(timer_event),
        .compare_event(compare_event), .capture_event(capture_event),
        .comparator1_output(comparator1_output),
        .comparator2_output(comparator2_output), .edge_pin(edge_pin),
        .unit_enable(unit_enable), .stop_in_idle(stop_in_idle),
        .edge1_occurred(edge1_occurred), .edge2_occurred(edge2_occurred),
        .current_source_on(current_source_on),
        .pulse_delay_gen_enable(pulse_delay_gen_enable),
        .sample_cap_discharge_enable(sample_cap_discharge_enable),
        .adc_trigger(adc_trigger), .current_trim(current_trim),
        .current_range(current_range));

    etctc_src_model SRC (.code(code), .lvl(lvl),
        .timer_event(timer_event), .compare_event(compare_event),
        .capture_event(capture_event),
        .comparator1_output(comparator1_output),
        .comparator2_output(comparator2_output), .edge_pin(edge_pin));

    always #12.5 hclk = ~hclk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h8020_0003 : 32'h0);
    endfunction

    function automatic logic [31:0] alias_exp(input logic [31:0] c,
        input logic [1:0] al, input logic [31:0] w);
        logic [31:0] n;
        case (al)
            ETCTC_ALIAS_WR: n = w;
            ETCTC_ALIAS_CLR: n = c & ~w;
            ETCTC_ALIAS_SET: n = c | w;
            default: n = c ^ w;
        endcase
        return n & ETCTC_WMASK;
    endfunction

    task automatic close_out;
        if (failures == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Hang guard, far above the fewer than a thousand cycles needed
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            close_out;
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic ahb(input logic wr, input logic [15:0] off,
        input logic [31:0] wd, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {16'h0, ETCTC_CTRL_OFF + off};
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        q = hrdata;
    endtask

    function automatic logic [31:0] st(input int ch);
        return {31'h0, ch ? edge2_occurred : edge1_occurred};
    endfunction

    task automatic edge_try(input int ch, input logic [3:0] c,
        input logic m, input logic p);
        logic [31:0] f;
        f = (32'h1 << ETCTC_ON_BIT) | (32'h1 << ETCTC_EDGEN_BIT)
            | ({31'h0, m} << ETCTC_MODE_BIT[ch])
            | ({31'h0, p} << ETCTC_POL_BIT[ch])
            | ({28'h0, c} << ETCTC_SEL_LSB[ch]);
        // Converter is taken as sampling while discharge is on
        ahb(1'b1, 16'h0, 32'h1 << ETCTC_DISCH_BIT, rd);
        @(posedge hclk);
        chk("discharge", {31'h0, sample_cap_discharge_enable},
            1);
        code <= c;
        // Edge mode starts at the active level: no edge yet
        lvl <= m ? p : ~p;
        ahb(1'b1, 16'h0, f, rd);
        repeat (3) @(posedge hclk);
        chk("status before", st(ch), 0);
        lvl <= ~p;
        repeat (3) @(posedge hclk);
        chk("status inactive", st(ch), 0);
        lvl <= p;
        repeat (3) @(posedge hclk);
        chk("status hit", st(ch),
            {31'h0, c != ETCTC_SRC_RSVD});
        if (m)
        begin
            ahb(1'b1, 16'h4, 32'h0300_0000, rd);
            @(posedge hclk);
            chk("status clear", st(ch), 0);
        end
    endtask

    initial
    begin
        ev = ETCTC_CTRL_RESET;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 16'h0, 32'h0, rd);
        chk("reset value", rd, ETCTC_CTRL_RESET);
        for (int i = 0; i < 24; i++)
        begin
            r = lfsr(r);
            // Keep edge detection off so status stays software owned
            d = r & ~(32'h1 << ETCTC_EDGEN_BIT);
            if (d[ETCTC_PULSE_DELAY_GEN_ENABLE_BIT])
                d[ETCTC_SEL_LSB[1] +: 4] = ETCTC_SRC_CMP2;
            r = lfsr(r);
            ahb(1'b1, {12'h0, r[1:0], 2'h0}, d, rd);
            ev = alias_exp(ev, r[1:0], d);
            ahb(1'b0, 16'h0, 32'h0, rd);
            chk("ctrl", rd, ev);
            chk("outputs", {unit_enable, stop_in_idle, pulse_delay_gen_enable,
                sample_cap_discharge_enable, edge2_occurred, edge1_occurred,
                current_trim, current_range},
                {ev[15], ev[13], ev[12], ev[9], ev[25:24], ev[7:0]});
        end
        ahb(1'b1, 16'h10, 32'hffff_ffff, rd);
        ahb(1'b0, 16'h10, 32'h0, rd);
        chk("unmapped read", rd, 32'h0);
        ahb(1'b0, 16'h0, 32'h0, rd);
        chk("unmapped write", rd, ev);
        for (int ch = 0; ch < 2; ch++)
            for (int c = 0; c < 16; c++)
                edge_try(ch, c[3:0], c[0] ^ ch[0], c[1]);
        // Both channels on rising edges; edge two waits for edge one
        ahb(1'b1, 16'h0, 32'h0, rd);
        code <= ETCTC_SRC_CMP2;
        lvl <= 1'b0;
        d = (32'h1 << ETCTC_ON_BIT) | (32'h1 << ETCTC_EDGEN_BIT)
            | (32'h1 << ETCTC_SEQEN_BIT) | (32'h1 << ETCTC_TRIG_BIT)
            | (32'h1 << ETCTC_PULSE_DELAY_GEN_ENABLE_BIT)
            | (32'h3 << ETCTC_POL_BIT[0]) | (32'h3 << ETCTC_POL_BIT[1])
            | ({28'h0, ETCTC_SRC_PIN1} << ETCTC_SEL_LSB[0])
            | ({28'h0, ETCTC_SRC_CMP2} << ETCTC_SEL_LSB[1]);
        ahb(1'b1, 16'h0, d, rd);
        repeat (3) @(posedge hclk);
        lvl <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("edge two early", st(1), 0);
        lvl <= 1'b0;
        repeat (3) @(posedge hclk);
        chk("current on", {31'h0, current_source_on}, 1);
        lvl <= 1'b1;
        repeat (2) @(posedge hclk);
        chk("trigger", {31'h0, adc_trigger}, 1);
        chk("current off", {31'h0, current_source_on}, 0);
        @(posedge hclk);
        chk("trigger end", {31'h0, adc_trigger}, 0);
        close_out;
    end
endmodule
